//--- design/pmr_pkg.sv
// Constants, carrier structs and state types for the MII receive status timing block.
// Assumes a single core clock of 40 MHz; every time is turned into core clock cycles here.
`default_nettype none

package pmr_pkg;

   // Core clock period
   localparam int CLK_NS = 25;

   // Bit times per speed
   localparam int BT100_NS = 10;
   localparam int BT10_NS  = 100;

   // Fixed latency in front of the carrier rise and collision lag counters: two sync flops and one edge register
   localparam int PRE_CYC = 3;

   // Latency windows in tenths of a bit time, as min and max
   localparam int DV_ON100_LO   = 30;
   localparam int DV_ON100_HI   = 50;
   localparam int CRS_ON100_LO  = 120;
   localparam int CRS_ON100_HI  = 160;
   localparam int CRS_OFF100_LO = 100;
   localparam int CRS_OFF100_HI = 170;
   localparam int COL_ON100_LO  = 160;
   localparam int COL_ON100_HI  = 220;
   localparam int COL_OFF100_LO = 170;
   localparam int COL_OFF100_HI = 200;
   localparam int RXLAT10_LO    = 42;
   localparam int RXLAT10_HI    = 66;
   localparam int DV_ON10_LO    = 50;
   localparam int DV_ON10_HI    = 320;
   localparam int CRS_TAIL10_LO = 3;
   localparam int CRS_TAIL10_HI = 5;
   localparam int CRS_ON10_LO   = 20;
   localparam int CRS_ON10_HI   = 280;
   localparam int CRS_OFF10_LO  = 60;
   localparam int CRS_OFF10_HI  = 100;
   localparam int COL_ON10_LO   = 10;
   localparam int COL_ON10_HI   = 310;
   localparam int COL_OFF10_LO  = 50;
   localparam int COL_OFF10_HI  = 100;

   // Heartbeat window in ns
   localparam int HB_DLY_MIN_NS = 650;
   localparam int HB_DLY_MAX_NS = 1600;
   localparam int HB_LEN_MIN_NS = 500;
   localparam int HB_LEN_MAX_NS = 1500;

   // Jabber windows in ms
   localparam int JAB_MIN_MS   = 20;
   localparam int JAB_MAX_MS   = 150;
   localparam int UNJAB_MIN_MS = 250;
   localparam int UNJAB_MAX_MS = 750;
   localparam int CYC_PER_MS   = 1000000 / CLK_NS;

   function automatic int ns_lo(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int ns_hi(input int ns);
      int c;
      c = ns / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // Midpoint of a window in tenths of a bit time, less the latency already spent
   function automatic logic [7:0] lag_mid(input int lo, input int hi, input int bt, input int pre);
      int m;
      m = (ns_lo((lo * bt) / 10) + ns_hi((hi * bt) / 10)) / 2 - pre;
      if (m < 0) begin
         m = 0;
      end
      return 8'(m);
   endfunction

   localparam logic [7:0] DV_ON100   = lag_mid(DV_ON100_LO, DV_ON100_HI, BT100_NS, 1);
   localparam logic [7:0] CRS_ON100  = lag_mid(CRS_ON100_LO, CRS_ON100_HI, BT100_NS, PRE_CYC);
   localparam logic [7:0] CRS_OFF100 = lag_mid(CRS_OFF100_LO, CRS_OFF100_HI, BT100_NS, 6);
   localparam logic [7:0] COL_ON100  = lag_mid(COL_ON100_LO, COL_ON100_HI, BT100_NS, PRE_CYC);
   localparam logic [7:0] COL_OFF100 = lag_mid(COL_OFF100_LO, COL_OFF100_HI, BT100_NS, PRE_CYC);
   localparam logic [7:0] DV_ON10    = lag_mid(DV_ON10_LO, DV_ON10_HI, BT10_NS, 1);
   localparam logic [7:0] CRS_ON10   = lag_mid(CRS_ON10_LO, CRS_ON10_HI, BT10_NS, PRE_CYC);
   localparam logic [7:0] CRS_OFF10  = lag_mid(CRS_OFF10_LO, CRS_OFF10_HI, BT10_NS, 6);
   localparam logic [7:0] COL_ON10   = lag_mid(COL_ON10_LO, COL_ON10_HI, BT10_NS, PRE_CYC);
   localparam logic [7:0] COL_OFF10  = lag_mid(COL_OFF10_LO, COL_OFF10_HI, BT10_NS, PRE_CYC);
   localparam logic [7:0] DV_OFF     = 8'h00;
   localparam int         CRS_TAIL   = ns_lo((CRS_TAIL10_LO * BT10_NS) / 10);

   // Receive data pipe depth at 10 Mbps; 100 Mbps taps the first stage
   localparam int RX_PIPE = lag_mid(RXLAT10_LO, RXLAT10_HI, BT10_NS, PRE_CYC);

   localparam logic [7:0] HB_DLY_CYC = 8'((ns_lo(HB_DLY_MIN_NS) + ns_hi(HB_DLY_MAX_NS)) / 2 - 4);
   localparam logic [7:0] HB_LEN_CYC = 8'((ns_lo(HB_LEN_MIN_NS) + ns_hi(HB_LEN_MAX_NS)) / 2);

   localparam int JAB_CYC_DEF   = (JAB_MIN_MS + JAB_MAX_MS) / 2 * CYC_PER_MS;
   localparam int UNJAB_CYC_DEF = (UNJAB_MIN_MS + UNJAB_MAX_MS) / 2 * CYC_PER_MS;

   typedef enum logic [2:0] {
      PMR_HB_IDLE  = 3'h1,
      PMR_HB_WAIT  = 3'h2,
      PMR_HB_PULSE = 3'h4
   } pmr_hb_t;

   // Input pin group, line pins with speed and MAC transmit enable, sampled together
   typedef struct packed {
      logic       spd;
      logic       act;
      logic       tx;
      logic       err;
      logic [3:0] data;
   } pmr_pins_t;

   typedef struct packed {
      logic       q;
      logic [7:0] cnt;
   } pmr_lag_st_t;

   typedef struct packed {
      pmr_pins_t                  s1;
      pmr_pins_t                  s2;
      logic [RX_PIPE-1:0][4:0]    pipe;
      logic                       tx_prev;
      logic                       tail;
      logic                       jab;
      logic [31:0]                tcnt;
      logic [31:0]                ucnt;
      pmr_hb_t                    hb;
      logic [7:0]                 hcnt;
      logic                       crs;
      logic                       col;
      logic                       rx_dv;
      logic                       rx_er;
      logic [3:0]                 rxd;
      logic                       line_tx_en;
   } pmr_state_t;

endpackage

`default_nettype wire

//--- design/pmr_lag.sv
// Level follower with separate rise and fall lags counted in core clock cycles.
// Assumes d is already synchronous to clk; a glitch shorter than the lag is swallowed.
`default_nettype none

module pmr_lag (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       d,
   input  wire logic [7:0] rise_cyc,
   input  wire logic [7:0] fall_cyc,
   output logic            q
);

   pmr_pkg::pmr_lag_st_t s;
   pmr_pkg::pmr_lag_st_t next_s;
   logic [7:0]           tgt;

   always_comb begin
      next_s = s;
      tgt    = s.q ? fall_cyc : rise_cyc;
      if (d == s.q) begin
         next_s.cnt = 8'h00;
      end else if (s.cnt >= tgt) begin
         next_s.q   = d;
         next_s.cnt = 8'h00;
      end else begin
         next_s.cnt = s.cnt + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.q;

   a_lag_exact: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(s.q) |-> ($past(d) == s.q) && ($past(s.cnt) == $past(tgt)))
      else $error("lag output changed before its count");

endmodule // pmr_lag

`default_nettype wire

//--- design/pmr_rx_status.sv
// MII receive status timing: carrier sense, collision, data valid, heartbeat and jabber.
// Assumes line pins and the MAC transmit enable are asynchronous; each passes two flops.
`default_nettype none

module pmr_rx_status #(
   parameter int unsigned JAB_CYC   = pmr_pkg::JAB_CYC_DEF,
   parameter int unsigned UNJAB_CYC = pmr_pkg::UNJAB_CYC_DEF
) (
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       speed_100,
   input  wire logic       line_receive_input,
   input  wire logic [3:0] line_data,
   input  wire logic       line_err,
   input  wire logic       tx_en,
   output logic            crs,
   output logic            col,
   output logic            rx_dv,
   output logic            rx_er,
   output logic [3:0]      rxd,
   output logic            line_tx_en,
   output logic            jabber
);

   logic [1:0]          rst_pipe;
   logic                rst_n;
   pmr_pkg::pmr_pins_t  pins;
   pmr_pkg::pmr_state_t s;
   pmr_pkg::pmr_state_t next_s;
   logic                crs_raw;
   logic                dv_raw;
   logic                col_raw;
   logic [7:0]          crs_rise;
   logic [7:0]          crs_fall;
   logic [7:0]          col_rise;
   logic [7:0]          col_fall;
   logic [7:0]          dv_rise;
   logic [4:0]          tap;
   logic                tx_fall;

   // Reset is released through two flops so every flop leaves reset on the same edge
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   assign rst_n = rst_pipe[1];

   always_comb begin
      pins      = '0;
      pins.spd  = speed_100;
      pins.act  = line_receive_input;
      pins.tx   = tx_en;
      pins.err  = line_err;
      pins.data = line_data;
   end

   // Bit time per speed folds into the lag counts chosen here
   always_comb begin
      if (s.s2.spd) begin
         crs_rise = pmr_pkg::CRS_ON100;
         crs_fall = pmr_pkg::CRS_OFF100;
         col_rise = pmr_pkg::COL_ON100;
         col_fall = pmr_pkg::COL_OFF100;
         dv_rise  = pmr_pkg::DV_ON100;
      end else begin
         crs_rise = pmr_pkg::CRS_ON10;
         crs_fall = pmr_pkg::CRS_OFF10;
         col_rise = pmr_pkg::COL_ON10;
         col_fall = pmr_pkg::COL_OFF10;
         dv_rise  = pmr_pkg::DV_ON10;
      end
   end

   // Carrier follows line receive activity at both speeds; only the lag counts differ by speed
   pmr_lag u_crs_lag (
      .clk      (core_clk),
      .rst_n    (rst_n),
      .d        (s.s2.act),
      .rise_cyc (crs_rise),
      .fall_cyc (crs_fall),
      .q        (crs_raw)
   );

   // Data valid trails carrier on the way up and drops one cycle after it on the way down
   pmr_lag u_dv_lag (
      .clk      (core_clk),
      .rst_n    (rst_n),
      .d        (crs_raw),
      .rise_cyc (dv_rise),
      .fall_cyc (pmr_pkg::DV_OFF),
      .q        (dv_raw)
   );

   // A collision is reception while the MAC transmits
   pmr_lag u_col_lag (
      .clk      (core_clk),
      .rst_n    (rst_n),
      .d        (s.s2.act & s.s2.tx),
      .rise_cyc (col_rise),
      .fall_cyc (col_fall),
      .q        (col_raw)
   );

   always_comb begin
      next_s    = s;
      next_s.s1 = pins;
      next_s.s2 = s.s1;

      // Receive data and error travel a pipe whose tap sets the line latency
      next_s.pipe = {s.pipe[pmr_pkg::RX_PIPE-2:0], {s.s2.err, s.s2.data}};
      tap         = s.s2.spd ? s.pipe[0] : s.pipe[pmr_pkg::RX_PIPE-1];
      next_s.rx_dv = dv_raw;
      next_s.rxd   = dv_raw ? tap[3:0] : 4'h0;
      next_s.rx_er = dv_raw & tap[4];

      // Carrier is held two cycles past data valid so it always drops last
      next_s.tail = s.rx_dv;
      next_s.crs  = crs_raw | s.rx_dv | s.tail;

      // Jabber only guards 10M transmission
      next_s.tx_prev = s.s2.tx;
      tx_fall        = s.tx_prev & ~s.s2.tx;
      if (!s.jab) begin
         if (s.s2.tx && !s.s2.spd) begin
            if (s.tcnt >= 32'(JAB_CYC - 1)) begin
               next_s.jab  = 1'b1;
               next_s.tcnt = 32'h0;
               next_s.ucnt = 32'h0;
            end else begin
               next_s.tcnt = s.tcnt + 32'h1;
            end
         end else begin
            next_s.tcnt = 32'h0;
         end
      end else begin
         if (s.ucnt < 32'(UNJAB_CYC)) begin
            next_s.ucnt = s.ucnt + 32'h1;
         end else if (!s.s2.tx) begin
            next_s.jab = 1'b0;
         end
      end
      next_s.line_tx_en = s.s2.tx & ~next_s.jab;

      // Heartbeat at 10M outside jabber: wait after the MAC stops, then a fixed pulse on collision
      case (s.hb)
         pmr_pkg::PMR_HB_IDLE: begin
            if (tx_fall && !s.s2.spd && !s.jab) begin
               next_s.hb   = pmr_pkg::PMR_HB_WAIT;
               next_s.hcnt = 8'h00;
            end
         end
         pmr_pkg::PMR_HB_WAIT: begin
            if (s.hcnt >= pmr_pkg::HB_DLY_CYC - 8'h01) begin
               next_s.hb   = pmr_pkg::PMR_HB_PULSE;
               next_s.hcnt = 8'h00;
            end else begin
               next_s.hcnt = s.hcnt + 8'h01;
            end
         end
         pmr_pkg::PMR_HB_PULSE: begin
            if (s.hcnt >= pmr_pkg::HB_LEN_CYC - 8'h01) begin
               next_s.hb   = pmr_pkg::PMR_HB_IDLE;
               next_s.hcnt = 8'h00;
            end else begin
               next_s.hcnt = s.hcnt + 8'h01;
            end
         end
         default: begin
            next_s.hb   = pmr_pkg::PMR_HB_IDLE;
            next_s.hcnt = 8'h00;
         end
      endcase

      // Collision output merges line collision, heartbeat and jabber
      next_s.col = col_raw | (s.hb == pmr_pkg::PMR_HB_PULSE) | s.jab;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s    <= '0;
         s.hb <= pmr_pkg::PMR_HB_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign crs        = s.crs;
   assign col        = s.col;
   assign rx_dv      = s.rx_dv;
   assign rx_er      = s.rx_er;
   assign rxd        = s.rxd;
   assign line_tx_en = s.line_tx_en;
   assign jabber     = s.jab;

   a_jab_inhibit: assert property (@(posedge core_clk) disable iff (!rst_n)
      jabber |-> !line_tx_en)
      else $error("transmit passed during jabber");

   a_jab_collide: assert property (@(posedge core_clk) disable iff (!rst_n)
      jabber |=> col)
      else $error("jabber without collision");

   a_jab_trip: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(jabber) |-> ($past(s.tcnt) == 32'(JAB_CYC - 1)) && $past(s.s2.tx))
      else $error("jabber at wrong transmit time");

   a_unjab_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(jabber) |-> ($past(s.ucnt) == 32'(UNJAB_CYC)) && !$past(s.s2.tx))
      else $error("jabber released early or with transmit on");

   a_dv_gates_data: assert property (@(posedge core_clk) disable iff (!rst_n)
      !rx_dv |-> (rxd == 4'h0) && !rx_er)
      else $error("receive data without data valid");

   a_dv_in_crs: assert property (@(posedge core_clk) disable iff (!rst_n)
      rx_dv |-> crs)
      else $error("data valid outside carrier");

   a_crs_tail: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(rx_dv) && !crs_raw && !$past(crs_raw) |-> crs ##1 (crs || crs_raw) ##1 (!crs || s.rx_dv || s.tail || crs_raw))
      else $error("carrier tail after data valid wrong");

   a_hb_width: assert property (@(posedge core_clk) disable iff (!rst_n)
      (s.hb == pmr_pkg::PMR_HB_PULSE) && (next_s.hb == pmr_pkg::PMR_HB_IDLE)
         |-> (s.hcnt == pmr_pkg::HB_LEN_CYC - 8'h01))
      else $error("heartbeat length wrong");

   // Output stage against the lag followers
   a_crs_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(crs_raw)
         |=> crs)
      else $error("carrier missed a raw rise");

   a_crs_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      !crs_raw && !rx_dv && !s.tail
         |=> !crs)
      else $error("carrier held without cause");

   a_dv_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(crs_raw)
         |-> ##2 !rx_dv)
      else $error("data valid outlived carrier");

   a_dv_after_crs: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(rx_dv)
         |-> $past(crs))
      else $error("data valid before carrier");

   a_er_in_dv: assert property (@(posedge core_clk) disable iff (!rst_n)
      rx_er
         |-> rx_dv)
      else $error("receive error without data valid");

   a_tail_set: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(rx_dv)
         |-> s.tail)
      else $error("carrier tail not started");

   a_col_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(col_raw)
         |=> col)
      else $error("collision missed a raw rise");

   a_col_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(col_raw) && (s.hb != pmr_pkg::PMR_HB_PULSE) && !s.jab
         |=> !col)
      else $error("collision held without cause");

   // Transmit gate and jabber guard
   a_tx_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      line_tx_en
         |-> $past(s.s2.tx))
      else $error("line transmit without MAC enable");

   a_tx_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(s.s2.tx) && !jabber
         |-> line_tx_en)
      else $error("transmit blocked outside jabber");

   a_jab_speed: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(jabber)
         |-> !$past(s.s2.spd))
      else $error("jabber tripped at 100M");

   a_jab_fast_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      s.s2.spd && !jabber
         |=> !jabber)
      else $error("jabber entered at 100M");

   a_tcnt_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      !s.s2.tx
         |=> (s.tcnt == 32'h0))
      else $error("transmit timer kept counting while idle");

   a_jab_stay: assert property (@(posedge core_clk) disable iff (!rst_n)
      jabber && (s.ucnt < 32'(UNJAB_CYC))
         |=> jabber)
      else $error("jabber left before unjabber time");

   a_jab_hold_tx: assert property (@(posedge core_clk) disable iff (!rst_n)
      jabber && s.s2.tx
         |=> jabber)
      else $error("jabber left with transmit on");

   // Heartbeat sequencing
   a_hb_start: assert property (@(posedge core_clk) disable iff (!rst_n)
      (s.hb == pmr_pkg::PMR_HB_IDLE) && (next_s.hb == pmr_pkg::PMR_HB_WAIT)
         |-> !s.s2.spd && !s.jab)
      else $error("heartbeat started at 100M or in jabber");

   a_hb_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
      (s.hb == pmr_pkg::PMR_HB_WAIT) && (next_s.hb == pmr_pkg::PMR_HB_PULSE)
         |-> (s.hcnt == pmr_pkg::HB_DLY_CYC - 8'h01))
      else $error("heartbeat delay wrong");

   a_hb_col: assert property (@(posedge core_clk) disable iff (!rst_n)
      (s.hb == pmr_pkg::PMR_HB_PULSE)
         |=> col)
      else $error("heartbeat not shown on collision");

endmodule // pmr_rx_status

`default_nettype wire

//--- test/pmr_line_model.sv
// Line-side partner: plays received streams onto the receive pins of the status block.
// Assumes the bench calls frame() and waits for it; nibbles follow a 200 ns link clock.
`default_nettype none

module pmr_line_model (
   output logic       line_receive_input,
   output logic [3:0] line_data,
   output logic       line_err
);
   timeunit 1ns;
   timeprecision 100ps;

   logic    lclk;
   realtime t_start;
   realtime t_end;
   realtime t_mark;

   initial begin
      lclk = 1'b0;
      line_receive_input = 1'b0;
      line_data = 4'h0;
      line_err = 1'b0;
   end

   // Link clock stands still between frames; mark nibble is unique so its latency can be timed
   task automatic frame(input int n, input int mark_at, input int err_at);
      #3;
      t_start = $realtime;
      line_receive_input = 1'b1;
      for (int i = 0; i < n; i++) begin
         lclk = 1'b1;
         line_data = (i == mark_at) ? 4'hA : 4'(i % 8);
         line_err = (i == err_at);
         if (i == mark_at) begin
            t_mark = $realtime;
         end
         #100;
         lclk = 1'b0;
         #100;
      end
      t_end = $realtime;
      line_receive_input = 1'b0;
      line_err = 1'b0;
      // Decoder output is undriven when quiet; show the inverse of the last nibble, which can equal the mark
      line_data = ~line_data;
   endtask

endmodule // pmr_line_model

`default_nettype wire

//--- test/pmr_rx_status_bench.sv
// Self-checking bench for the MII receive status timing block.
// Assumes the line model drives the receive pins; the bench drives speed, tx_en and reset.
`default_nettype none

module pmr_rx_status_bench;
   timeunit 1ns;
   timeprecision 100ps;

   // Shortened jabber counts keep the run brief
   localparam int JAB   = 1000;
   localparam int UNJAB = 1500;
   localparam int CK    = pmr_pkg::CLK_NS;

   logic       core_clk;
   logic       nrst;
   logic       speed_100;
   logic       tx_en;
   logic       line_receive_input;
   logic [3:0] line_data;
   logic       line_err;
   logic       crs;
   logic       col;
   logic       rx_dv;
   logic       rx_er;
   logic [3:0] rxd;
   logic       line_tx_en;
   logic       jabber;
   int         fails;
   int         total_checks;
   realtime    on_t[4];
   realtime    off_t[4];
   realtime    t_dat;
   logic       er_seen;

   pmr_rx_status #(.JAB_CYC(JAB), .UNJAB_CYC(UNJAB)) i_dut (
      .core_clk           (core_clk),
      .nrst               (nrst),
      .speed_100          (speed_100),
      .line_receive_input (line_receive_input),
      .line_data          (line_data),
      .line_err           (line_err),
      .tx_en              (tx_en),
      .crs                (crs),
      .col                (col),
      .rx_dv              (rx_dv),
      .rx_er              (rx_er),
      .rxd                (rxd),
      .line_tx_en         (line_tx_en),
      .jabber             (jabber)
   );

   pmr_line_model i_line (
      .line_receive_input (line_receive_input),
      .line_data          (line_data),
      .line_err           (line_err)
   );

   initial core_clk = 1'b0;
   always #(CK / 2.0) core_clk = ~core_clk;

   // Edge times of the status outputs: 0 crs, 1 col, 2 rx_dv, 3 jabber
   always @(posedge crs) on_t[0] = $realtime;
   always @(negedge crs) off_t[0] = $realtime;
   always @(posedge col) on_t[1] = $realtime;
   always @(negedge col) off_t[1] = $realtime;
   always @(posedge rx_dv) on_t[2] = $realtime;
   always @(negedge rx_dv) off_t[2] = $realtime;
   always @(posedge jabber) on_t[3] = $realtime;
   always @(negedge jabber) off_t[3] = $realtime;
   // Only the first mark counts: the quiet value after a frame can also read as the mark
   always @(rxd) if (rxd === 4'hA && t_dat == 0) t_dat = $realtime;
   always @(posedge rx_er) er_seen = 1'b1;

   task automatic chk(input logic ok, input string what);
      total_checks++;
      if (ok !== 1'b1) begin
         fails++;
         $display("unexpected at %0t: %s", $realtime, what);
      end
   endtask

   // Bounds in tenths of bt ns; one core clock either side covers pin sampling
   task automatic win(input realtime d, input int lo, input int hi, input int bt, input string what);
      chk(d >= lo * bt / 10.0 - CK && d <= hi * bt / 10.0 + CK, what);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic clear();
      foreach (on_t[k]) begin
         on_t[k] = 0;
         off_t[k] = 0;
      end
      t_dat = 0;
      er_seen = 1'b0;
   endtask

   task automatic t_rx100(input logic coll);
      realtime ts;
      realtime te;
      int      bt;
      clear();
      bt = pmr_pkg::BT100_NS;
      speed_100 = 1'b1;
      tx_en = coll;
      cyc(20);
      i_line.frame(12, -1, -1);
      ts = i_line.t_start;
      te = i_line.t_end;
      cyc(40);
      tx_en = 1'b0;
      cyc(100);
      win(on_t[0] - ts, pmr_pkg::CRS_ON100_LO, pmr_pkg::CRS_ON100_HI, bt, "crs on");
      win(on_t[2] - on_t[0], pmr_pkg::DV_ON100_LO, pmr_pkg::DV_ON100_HI, bt, "dv");
      win(off_t[0] - te, pmr_pkg::CRS_OFF100_LO, pmr_pkg::CRS_OFF100_HI, bt, "crs off");
      if (coll) begin
         win(on_t[1] - ts, pmr_pkg::COL_ON100_LO, pmr_pkg::COL_ON100_HI, bt, "col on");
         win(off_t[1] - te, pmr_pkg::COL_OFF100_LO, pmr_pkg::COL_OFF100_HI, bt, "col");
         chk(on_t[1] < te, "heartbeat at 100M");
      end else begin
         chk(on_t[1] == 0, "col without transmit");
      end
      $display("done: rx100, collision %0b", coll);
   endtask

   task automatic t_rx10();
      realtime ts;
      realtime te;
      realtime tc_on;
      realtime tc_off;
      realtime tx_off;
      int      bt;
      clear();
      bt = pmr_pkg::BT10_NS;
      speed_100 = 1'b0;
      tx_en = 1'b1;
      cyc(20);
      i_line.frame(30, 25, 20);
      ts = i_line.t_start;
      te = i_line.t_end;
      cyc(60);
      tc_on = on_t[1];
      tc_off = off_t[1];
      tx_en = 1'b0;
      tx_off = $realtime;
      cyc(200);
      win(on_t[0] - ts, pmr_pkg::CRS_ON10_LO, pmr_pkg::CRS_ON10_HI, bt, "crs on");
      win(on_t[2] - on_t[0], pmr_pkg::DV_ON10_LO, pmr_pkg::DV_ON10_HI, bt, "dv");
      win(t_dat - i_line.t_mark, pmr_pkg::RXLAT10_LO, pmr_pkg::RXLAT10_HI, bt, "data");
      chk(er_seen, "error nibble lost");
      win(off_t[0] - te, pmr_pkg::CRS_OFF10_LO, pmr_pkg::CRS_OFF10_HI, bt, "crs off");
      win(off_t[0] - off_t[2], pmr_pkg::CRS_TAIL10_LO, pmr_pkg::CRS_TAIL10_HI, bt, "tail");
      win(tc_on - ts, pmr_pkg::COL_ON10_LO, pmr_pkg::COL_ON10_HI, bt, "col on");
      win(tc_off - te, pmr_pkg::COL_OFF10_LO, pmr_pkg::COL_OFF10_HI, bt, "col off");
      win(on_t[1] - tx_off, pmr_pkg::HB_DLY_MIN_NS, pmr_pkg::HB_DLY_MAX_NS, 10, "hb gap");
      win(off_t[1] - on_t[1], pmr_pkg::HB_LEN_MIN_NS, pmr_pkg::HB_LEN_MAX_NS, 10, "hb");
      $display("done: rx10 with collision and heartbeat");
   endtask

   task automatic t_jabber();
      realtime t0;
      clear();
      speed_100 = 1'b0;
      tx_en = 1'b1;
      t0 = $realtime;
      cyc(8);
      chk(line_tx_en === 1'b1 && jabber === 1'b0, "transmit blocked");
      cyc(JAB + 20);
      win(on_t[3] - t0, JAB * CK, (JAB + 4) * CK, 10, "jabber onset");
      chk(line_tx_en === 1'b0 && col === 1'b1, "jabber not enforced");
      cyc(UNJAB + 20);
      chk(jabber === 1'b1, "released with transmit on");
      tx_en = 1'b0;
      cyc(10);
      chk(jabber === 1'b0 && off_t[3] - on_t[3] >= UNJAB * CK, "unjabber span");
      tx_en = 1'b1;
      cyc(8);
      chk(line_tx_en === 1'b1 && col === 1'b0, "transmit not resumed");
      tx_en = 1'b0;
      cyc(200);
      $display("done: jabber and unjabber");
   endtask

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      nrst = 1'b0;
      speed_100 = 1'b1;
      tx_en = 1'b0;
      fails = 0;
      total_checks = 0;
      cyc(10);
      chk({crs, col, rx_dv, rx_er, rxd, line_tx_en, jabber} === 10'h000, "busy in reset");
      cyc(6);
      nrst = 1'b1;
      cyc(8);
      t_rx100(1'b0);
      t_rx100(1'b1);
      t_rx10();
      t_jabber();
      stop_test();
   end

   // Whole run needs about 4000 cycles
   initial begin
      cyc(20000);
      fails++;
      $display("unexpected at %0t: run hung", $realtime);
      stop_test();
   end

endmodule // pmr_rx_status_bench

`default_nettype wire
